// >>> logic/frsb_map.svh
// register offsets, bit positions, reset values and packet codes of the fault status bank
// assumes a single byte-wide register space reached over the i2c slave port
`ifndef FRSB_MAP_SVH
`define FRSB_MAP_SVH

`define FRSB_I2C_ADDR 7'h68
`define FRSB_OFS_PKT_MASK_HI 8'h00
`define FRSB_OFS_PKT_MASK_LO 8'h01
`define FRSB_OFS_ALERT_MASK_HI 8'h02
`define FRSB_OFS_ALERT_MASK_LO 8'h03
`define FRSB_OFS_RAW_HI 8'hD4
`define FRSB_OFS_RAW_LO 8'hD5
`define FRSB_OFS_GATED_HI 8'hD6
`define FRSB_OFS_GATED_LO 8'hD7
`define FRSB_OFS_ALERT_HI 8'hD8
`define FRSB_OFS_ALERT_LO 8'hD9
`define FRSB_OFS_PART_UPPER 8'hFC
`define FRSB_OFS_PART_LOWER 8'hFD
`define FRSB_OFS_FW_REV 8'hFF

`define FRSB_BIT_THERM_TWO 7
`define FRSB_BIT_THERM_ONE 6
`define FRSB_BIT_DIE_HOT 5
`define FRSB_BIT_CHARGE_DONE 2
`define FRSB_BIT_SHUTDOWN_REQ 0

`define FRSB_RST_PKT_MASK_HI 8'h0F
`define FRSB_RST_PKT_MASK_LO 8'hFF
`define FRSB_RST_ALERT_MASK_HI 8'hFF
`define FRSB_RST_ALERT_MASK_LO 8'hFF

`define FRSB_CODE_CHARGE_DONE 8'h01
`define FRSB_CODE_DIE_HOT 8'h02
`define FRSB_CODE_SHUTDOWN_REQ 8'h02
`define FRSB_CODE_THERM 8'h03

`endif

// >>> logic/frsb_pkg.sv
// types shared by the fault status bank
// assumes frsb_map.svh carries the numbers
`default_nettype none
package frsb_pkg;

    typedef enum logic [3:0] {
        FRSB_IDLE, FRSB_ADDR, FRSB_AACK, FRSB_PTR, FRSB_PACK,
        FRSB_WDATA, FRSB_DACK, FRSB_RDATA, FRSB_RACK, FRSB_RLOAD
    } frsb_state_type;

    typedef struct packed {
        logic therm_two;
        logic therm_one;
        logic die_hot;
        logic charge_done;
        logic shutdown_req;
    } frsb_faults_type;

endpackage : frsb_pkg

`default_nettype wire

// >>> logic/frsb_fault_bank.sv
// fault status register bank with i2c slave port, packet request and alert pin
// assumes scl and sda are already synchronous to clk_in; sda and alert are open drain
//
// Operation
// - answer i2c at seven-bit address 0x68
// - part code readable at 0xFC and 0xFD
// - firmware revision read-only at 0xFF
// - each fault sends packet or raises alert; faults rising together or while one is pending share one packet
// - unfiltered flags set regardless of enables
// - low byte bits 7,6,5,2,0; others zero
// - gated fault flags need fault and mask
// - charge complete sends packet code 0x01
// - die over-temperature sends packet code 0x02
// - shutdown request sends packet code 0x02
// - either thermistor sends packet code 0x03
// - gated alert flags need fault and mask
// - packet mask one allows the packet
// - alert mask one allows the alert
// - alert is open-drain and active low
`include "frsb_map.svh"
`timescale 1ns/100ps
`default_nettype none

module frsb_fault_bank #(
    parameter logic [7:0] PART_UPPER_RST = 8'h5A, // arbitrary value
    parameter logic [7:0] PART_LOWER_RST = 8'hC3, // arbitrary value
    parameter logic [7:0] FW_REVISION = 8'h11 // arbitrary value
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // i2c pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // fault sources
    input wire frsb_pkg::frsb_faults_type faults_in,
    // packet request to the modulator
    output logic pkt_valid_out,
    input wire logic pkt_ready_in,
    output logic [7:0] pkt_code_out,
    // alert pin
    output logic alert_n_out,
    output logic alert_oe_out
);

    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // fault flag path
    frsb_pkg::frsb_faults_type raw_q, raw_d;
    frsb_pkg::frsb_faults_type pkt_mask_f, alert_mask_f;
    frsb_pkg::frsb_faults_type gated_q, gated_d, alert_q, alert_d;
    logic [7:0] pkt_mask_hi_q, pkt_mask_hi_d, pkt_mask_lo_q, pkt_mask_lo_d;
    logic [7:0] alert_mask_hi_q, alert_mask_hi_d, alert_mask_lo_q, alert_mask_lo_d;
    logic [7:0] part_upper_q, part_upper_d, part_lower_q, part_lower_d;
    logic pkt_pend_q, pkt_pend_d;
    logic [7:0] pkt_code_q, pkt_code_d;
    frsb_pkg::frsb_faults_type fresh;

    function automatic logic [7:0] frsb_to_byte(input frsb_pkg::frsb_faults_type f);
        logic [7:0] b;
        b = 8'h00;
        b[`FRSB_BIT_THERM_TWO] = f.therm_two;
        b[`FRSB_BIT_THERM_ONE] = f.therm_one;
        b[`FRSB_BIT_DIE_HOT] = f.die_hot;
        b[`FRSB_BIT_CHARGE_DONE] = f.charge_done;
        b[`FRSB_BIT_SHUTDOWN_REQ] = f.shutdown_req;
        return b;
    endfunction : frsb_to_byte

    function automatic frsb_pkg::frsb_faults_type frsb_from_byte(input logic [7:0] b);
        frsb_pkg::frsb_faults_type f;
        f.therm_two = b[`FRSB_BIT_THERM_TWO];
        f.therm_one = b[`FRSB_BIT_THERM_ONE];
        f.die_hot = b[`FRSB_BIT_DIE_HOT];
        f.charge_done = b[`FRSB_BIT_CHARGE_DONE];
        f.shutdown_req = b[`FRSB_BIT_SHUTDOWN_REQ];
        return f;
    endfunction : frsb_from_byte

    // i2c slave state
    frsb_pkg::frsb_state_type st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] ptr_q, ptr_d;
    logic rw_q, rw_d;
    logic oe_q, oe_d;
    logic scl_prev_q, sda_prev_q;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic wr_en;
    logic [7:0] rd_data;

    assign scl_rise = scl_in & ~scl_prev_q;
    assign scl_fall = ~scl_in & scl_prev_q;
    assign start_seen = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
    assign stop_seen = scl_in & scl_prev_q & ~sda_prev_q & sda_in;

    // reads are pure muxes, a read changes nothing but the pointer
    always_comb begin
        unique case (ptr_q)
            `FRSB_OFS_PKT_MASK_HI: rd_data = pkt_mask_hi_q;
            `FRSB_OFS_PKT_MASK_LO: rd_data = pkt_mask_lo_q;
            `FRSB_OFS_ALERT_MASK_HI: rd_data = alert_mask_hi_q;
            `FRSB_OFS_ALERT_MASK_LO: rd_data = alert_mask_lo_q;
            `FRSB_OFS_RAW_LO: rd_data = frsb_to_byte(raw_q);
            `FRSB_OFS_GATED_LO: rd_data = frsb_to_byte(gated_q);
            `FRSB_OFS_ALERT_LO: rd_data = frsb_to_byte(alert_q);
            `FRSB_OFS_PART_UPPER: rd_data = part_upper_q;
            `FRSB_OFS_PART_LOWER: rd_data = part_lower_q;
            `FRSB_OFS_FW_REV: rd_data = FW_REVISION;
            default: rd_data = 8'h00;
        endcase
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        oe_d = oe_q;
        wr_en = 1'b0;
        if (start_seen) begin
            st_d = frsb_pkg::FRSB_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_seen) begin
            st_d = frsb_pkg::FRSB_IDLE;
            oe_d = 1'b0;
        end else if (scl_rise) begin
            unique case (st_q)
                frsb_pkg::FRSB_ADDR, frsb_pkg::FRSB_PTR, frsb_pkg::FRSB_WDATA: begin
                    if (cnt_q < 4'h8) begin
                        shift_d = {shift_q[6:0], sda_in};
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                frsb_pkg::FRSB_RACK: begin
                    // master nack ends the read burst
                    st_d = sda_in ? frsb_pkg::FRSB_IDLE : frsb_pkg::FRSB_RLOAD;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (st_q)
                frsb_pkg::FRSB_ADDR: begin
                    if (cnt_q == 4'h8) begin
                        if (shift_q[7:1] == `FRSB_I2C_ADDR) begin
                            rw_d = shift_q[0];
                            st_d = frsb_pkg::FRSB_AACK;
                            oe_d = 1'b1;
                        end else begin
                            st_d = frsb_pkg::FRSB_IDLE;
                        end
                    end
                end
                frsb_pkg::FRSB_AACK, frsb_pkg::FRSB_RLOAD: begin
                    if (rw_q) begin
                        oe_d = ~rd_data[7];
                        shift_d = {rd_data[6:0], 1'b0};
                        ptr_d = ptr_q + 8'h01;
                        cnt_d = 4'h1;
                        st_d = frsb_pkg::FRSB_RDATA;
                    end else begin
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                        st_d = frsb_pkg::FRSB_PTR;
                    end
                end
                frsb_pkg::FRSB_PTR: begin
                    if (cnt_q == 4'h8) begin
                        ptr_d = shift_q;
                        st_d = frsb_pkg::FRSB_PACK;
                        oe_d = 1'b1;
                    end
                end
                frsb_pkg::FRSB_PACK, frsb_pkg::FRSB_DACK: begin
                    oe_d = 1'b0;
                    cnt_d = 4'h0;
                    st_d = frsb_pkg::FRSB_WDATA;
                end
                frsb_pkg::FRSB_WDATA: begin
                    if (cnt_q == 4'h8) begin
                        wr_en = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                        st_d = frsb_pkg::FRSB_DACK;
                        oe_d = 1'b1;
                    end
                end
                frsb_pkg::FRSB_RDATA: begin
                    if (cnt_q == 4'h8) begin
                        oe_d = 1'b0;
                        st_d = frsb_pkg::FRSB_RACK;
                    end else begin
                        oe_d = ~shift_q[7];
                        shift_d = {shift_q[6:0], 1'b0};
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // register writes and fault path
    always_comb begin
        pkt_mask_hi_d = pkt_mask_hi_q;
        pkt_mask_lo_d = pkt_mask_lo_q;
        alert_mask_hi_d = alert_mask_hi_q;
        alert_mask_lo_d = alert_mask_lo_q;
        part_upper_d = part_upper_q;
        part_lower_d = part_lower_q;
        if (wr_en) begin
            unique case (ptr_q)
                `FRSB_OFS_PKT_MASK_HI: pkt_mask_hi_d = shift_q;
                `FRSB_OFS_PKT_MASK_LO: pkt_mask_lo_d = shift_q;
                `FRSB_OFS_ALERT_MASK_HI: alert_mask_hi_d = shift_q;
                `FRSB_OFS_ALERT_MASK_LO: alert_mask_lo_d = shift_q;
                `FRSB_OFS_PART_UPPER: part_upper_d = shift_q;
                `FRSB_OFS_PART_LOWER: part_lower_d = shift_q;
                default: begin
                end
            endcase
        end
        pkt_mask_f = frsb_from_byte(pkt_mask_lo_q);
        alert_mask_f = frsb_from_byte(alert_mask_lo_q);
        raw_d = faults_in;
        gated_d = raw_q & pkt_mask_f;
        alert_d = raw_q & alert_mask_f;
        // only a newly gated fault asks for a packet, so a standing one is not resent
        fresh = gated_d & ~gated_q;
        pkt_pend_d = pkt_pend_q;
        pkt_code_d = pkt_code_q;
        if (pkt_pend_q && pkt_ready_in) begin
            pkt_pend_d = 1'b0;
        end
        if (|fresh) begin
            pkt_pend_d = 1'b1;
            if (fresh.die_hot) begin
                pkt_code_d = `FRSB_CODE_DIE_HOT;
            end else if (fresh.shutdown_req) begin
                pkt_code_d = `FRSB_CODE_SHUTDOWN_REQ;
            end else if (fresh.therm_one || fresh.therm_two) begin
                pkt_code_d = `FRSB_CODE_THERM;
            end else begin
                pkt_code_d = `FRSB_CODE_CHARGE_DONE;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            st_q <= frsb_pkg::FRSB_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            raw_q <= '0;
            gated_q <= '0;
            alert_q <= '0;
            pkt_mask_hi_q <= `FRSB_RST_PKT_MASK_HI;
            pkt_mask_lo_q <= `FRSB_RST_PKT_MASK_LO;
            alert_mask_hi_q <= `FRSB_RST_ALERT_MASK_HI;
            alert_mask_lo_q <= `FRSB_RST_ALERT_MASK_LO;
            part_upper_q <= PART_UPPER_RST;
            part_lower_q <= PART_LOWER_RST;
            pkt_pend_q <= 1'b0;
            pkt_code_q <= 8'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
            scl_prev_q <= scl_in;
            sda_prev_q <= sda_in;
            raw_q <= raw_d;
            gated_q <= gated_d;
            alert_q <= alert_d;
            pkt_mask_hi_q <= pkt_mask_hi_d;
            pkt_mask_lo_q <= pkt_mask_lo_d;
            alert_mask_hi_q <= alert_mask_hi_d;
            alert_mask_lo_q <= alert_mask_lo_d;
            part_upper_q <= part_upper_d;
            part_lower_q <= part_lower_d;
            pkt_pend_q <= pkt_pend_d;
            pkt_code_q <= pkt_code_d;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = oe_q;
    assign pkt_valid_out = pkt_pend_q;
    assign pkt_code_out = pkt_code_q;
    assign alert_n_out = 1'b0;
    assign alert_oe_out = |alert_q;

endmodule : frsb_fault_bank

`default_nettype wire

// >>> tb/frsb_fault_bank_monitor.sv
// port assertions of the fault bank
// assumes binding to frsb_fault_bank
`timescale 1ns/100ps
`default_nettype none
module frsb_fault_bank_monitor (
    // clock, reset, i2c
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    // faults, packet, alert
    input wire frsb_pkg::frsb_faults_type faults_in,
    input wire logic pkt_valid_out,
    input wire logic pkt_ready_in,
    input wire logic [7:0] pkt_code_out,
    input wire logic alert_n_out,
    input wire logic alert_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    property p_open_drain;
        alert_n_out == 1'b0 && sda_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin value not low");
    // data may only move while scl is low
    property p_sda_still;
        scl_in && $past(scl_in) |-> $stable(sda_oe_out);
    endproperty
    a_sda_still: assert property (p_sda_still) else $error("sda moved with scl high");
    property p_pkt_hold;
        pkt_valid_out && !pkt_ready_in |=> pkt_valid_out;
    endproperty
    a_pkt_hold: assert property (p_pkt_hold) else $error("packet dropped");
    property p_pkt_clear;
        $stable(faults_in) [*4] ##0 (pkt_valid_out && pkt_ready_in) |=> !pkt_valid_out;
    endproperty
    a_pkt_clear: assert property (p_pkt_clear) else $error("packet repeated");
    property p_code_charge;
        $rose(pkt_valid_out) && $past(faults_in) == 5'b00010 |-> pkt_code_out == 8'h01;
    endproperty
    a_code_charge: assert property (p_code_charge) else $error("charge code");
    property p_code_die;
        $rose(pkt_valid_out) && $past(faults_in) == 5'b00100 |-> pkt_code_out == 8'h02;
    endproperty
    a_code_die: assert property (p_code_die) else $error("die code");
    property p_code_shut;
        $rose(pkt_valid_out) && $past(faults_in) == 5'b00001 |-> pkt_code_out == 8'h02;
    endproperty
    a_code_shut: assert property (p_code_shut) else $error("shutdown code");
    property p_code_therm;
        $rose(pkt_valid_out) && $past(faults_in) inside {5'b10000, 5'b01000} |-> pkt_code_out == 8'h03;
    endproperty
    a_code_therm: assert property (p_code_therm) else $error("thermistor code");
    property p_alert_idle;
        (faults_in == 5'b00000) [*4] |-> !alert_oe_out;
    endproperty
    a_alert_idle: assert property (p_alert_idle) else $error("alert without fault");
    c_accept: cover property (pkt_valid_out && pkt_ready_in);
    c_alert: cover property ($rose(alert_oe_out));
    c_ack: cover property ($rose(sda_oe_out));
endmodule : frsb_fault_bank_monitor
`default_nettype wire

// >>> tb/frsb_xmit_model.sv
// transmitter model: takes a packet after a set delay
// assumes the clock of the fault bank
`timescale 1ns/100ps
`default_nettype none
module frsb_xmit_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // packet request
    input wire logic valid_in,
    input wire logic [7:0] code_in,
    input wire logic [3:0] delay_in,
    output logic ready_out,
    // accepted packets
    output logic [7:0] count_out,
    output logic [7:0] last_out
);
    logic [3:0] wait_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ready_out <= 1'b0;
            wait_q <= 4'h0;
            count_out <= 8'h00;
            last_out <= 8'h00;
        end else if (valid_in && ready_out) begin
            ready_out <= 1'b0;
            wait_q <= 4'h0;
            count_out <= count_out + 8'h01;
            last_out <= code_in;
        end else if (valid_in) begin
            ready_out <= wait_q >= delay_in;
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : frsb_xmit_model
`default_nettype wire

// >>> tb/tb_fault_status_register_bank.sv
// testbench of the fault bank: i2c host and scenarios
// assumes a pull-up on sda
`include "frsb_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_fault_status_register_bank;
    logic clk_in, resetn_in, scl_q, sda_q, sda_oe, alert_oe, pkt_valid, pkt_ready, sda_w;
    logic [7:0] pkt_code, pkt_cnt, pkt_last;
    logic [3:0] delay_q;
    frsb_pkg::frsb_faults_type faults_q;
    int err_total, comparisons;
    assign sda_w = sda_q & ~sda_oe;
    // identity values are arbitrary
    frsb_fault_bank #(.PART_UPPER_RST(8'h3C), .PART_LOWER_RST(8'h4D), .FW_REVISION(8'h21)) dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_q), .sda_in(sda_w), .sda_out(),
        .sda_oe_out(sda_oe), .faults_in(faults_q), .pkt_valid_out(pkt_valid), .pkt_ready_in(pkt_ready),
        .pkt_code_out(pkt_code), .alert_n_out(), .alert_oe_out(alert_oe));
    frsb_xmit_model xmit (.clk_in(clk_in), .resetn_in(resetn_in), .valid_in(pkt_valid), .code_in(pkt_code),
        .delay_in(delay_q), .ready_out(pkt_ready), .count_out(pkt_cnt), .last_out(pkt_last));
    task automatic clks(input int n);
        repeat (n) @(posedge clk_in);
    endtask : clks
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    task automatic pin_bit(input logic b, output logic r);
        scl_q <= 1'b0;
        clks(2);
        sda_q <= b;
        clks(2);
        scl_q <= 1'b1;
        clks(2);
        #1 r = sda_w;
        clks(1);
    endtask : pin_bit
    // one gives a start, zero a stop
    task automatic pin_cond(input logic s);
        scl_q <= 1'b0;
        clks(2);
        sda_q <= s;
        clks(2);
        scl_q <= 1'b1;
        clks(3);
        sda_q <= ~s;
        clks(3);
    endtask : pin_cond
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) pin_bit(v[i], r);
        pin_bit(1'b1, r);
        ack = ~r;
    endtask : put_byte
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        pin_cond(1'b1);
        put_byte(8'hD0, k);
        check("addr ack", 8'h01, {7'h00, k});
        put_byte(a, k);
        put_byte(d, k);
        pin_cond(1'b0);
    endtask : reg_wr
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic k;
        logic [7:0] d;
        pin_cond(1'b1);
        put_byte(8'hD0, k);
        put_byte(a, k);
        pin_cond(1'b1);
        put_byte(8'hD1, k);
        for (int i = 7; i >= 0; i--) pin_bit(1'b1, d[i]);
        pin_bit(1'b1, k);
        pin_cond(1'b0);
        check(what, exp, d);
    endtask : rd_chk
    task automatic t_ident;
        logic k;
        rd_chk("part upper", `FRSB_OFS_PART_UPPER, 8'h3C);
        rd_chk("part lower", `FRSB_OFS_PART_LOWER, 8'h4D);
        rd_chk("packet mask high", `FRSB_OFS_PKT_MASK_HI, `FRSB_RST_PKT_MASK_HI);
        rd_chk("alert mask low", `FRSB_OFS_ALERT_MASK_LO, `FRSB_RST_ALERT_MASK_LO);
        reg_wr(`FRSB_OFS_FW_REV, 8'h00);
        rd_chk("firmware", `FRSB_OFS_FW_REV, 8'h21);
        reg_wr(`FRSB_OFS_PART_UPPER, 8'hA5);
        rd_chk("part written", `FRSB_OFS_PART_UPPER, 8'hA5);
        rd_chk("unmapped", 8'h80, 8'h00);
        pin_cond(1'b1);
        put_byte(8'hA0, k);
        pin_cond(1'b0);
        check("foreign ack", 8'h00, {7'h00, k});
        $display("ident test done");
    endtask : t_ident
    task automatic t_raw;
        reg_wr(`FRSB_OFS_PKT_MASK_LO, 8'h00);
        reg_wr(`FRSB_OFS_ALERT_MASK_LO, 8'h00);
        faults_q <= 5'b11111;
        clks(6);
        rd_chk("raw low", `FRSB_OFS_RAW_LO, 8'hE5);
        rd_chk("raw high", `FRSB_OFS_RAW_HI, 8'h00);
        rd_chk("gated low", `FRSB_OFS_GATED_LO, 8'h00);
        rd_chk("gated high", `FRSB_OFS_GATED_HI, 8'h00);
        rd_chk("alert high", `FRSB_OFS_ALERT_HI, 8'h00);
        rd_chk("alert low", `FRSB_OFS_ALERT_LO, 8'h00);
        check("alert pin", 8'h00, {7'h00, alert_oe});
        check("packets", 8'h00, pkt_cnt);
        faults_q <= 5'b00000;
        clks(6);
        rd_chk("raw cleared", `FRSB_OFS_RAW_LO, 8'h00);
        $display("raw test done");
    endtask : t_raw
    task automatic t_codes;
        logic [4:0] src [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
        logic [7:0] code [5] = '{8'h03, 8'h03, 8'h02, 8'h01, 8'h02};
        logic [7:0] bits [5] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h01};
        logic [7:0] n;
        int w;
        reg_wr(`FRSB_OFS_PKT_MASK_LO, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            n = pkt_cnt;
            w = 0;
            delay_q <= 4'(i * 2);
            faults_q <= src[i];
            clks(1);
            while (pkt_cnt === n && w < 60) begin
                clks(1);
                w++;
            end
            if (w == 60) begin
                err_total++;
                $display("MISMATCH packet wait expected accept seen timeout");
                close_out();
            end
            check("packet code", code[i], pkt_last);
            rd_chk("gated low", `FRSB_OFS_GATED_LO, bits[i]);
            check("one packet", n + 8'h01, pkt_cnt);
            faults_q <= 5'b00000;
            clks(6);
        end
        $display("code test done");
    endtask : t_codes
    task automatic t_alert;
        logic [7:0] n;
        n = pkt_cnt;
        reg_wr(`FRSB_OFS_PKT_MASK_LO, 8'h00);
        reg_wr(`FRSB_OFS_ALERT_MASK_LO, 8'h04);
        faults_q <= 5'b00100;
        clks(8);
        check("alert masked", 8'h00, {7'h00, alert_oe});
        faults_q <= 5'b00010;
        clks(8);
        check("alert raised", 8'h01, {7'h00, alert_oe});
        rd_chk("alert flags", `FRSB_OFS_ALERT_LO, 8'h04);
        check("blocked packet", n, pkt_cnt);
        faults_q <= 5'b00000;
        clks(8);
        check("alert gone", 8'h00, {7'h00, alert_oe});
        $display("alert test done");
    endtask : t_alert
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        resetn_in = 1'b0;
        scl_q = 1'b1;
        sda_q = 1'b1;
        faults_q = 5'b00000;
        delay_q = 4'h0;
        err_total = 0;
        comparisons = 0;
        clks(2);
        resetn_in <= 1'b1;
        clks(4);
        t_ident();
        t_raw();
        t_codes();
        t_alert();
        close_out();
    end
endmodule : tb_fault_status_register_bank
bind frsb_fault_bank frsb_fault_bank_monitor mon (.clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .faults_in(faults_in),
    .pkt_valid_out(pkt_valid_out), .pkt_ready_in(pkt_ready_in), .pkt_code_out(pkt_code_out),
    .alert_n_out(alert_n_out), .alert_oe_out(alert_oe_out));
`default_nettype wire
